//--- include/ifb_pkg.sv
// Package for the interrupt flag and enable bank: register map, bit layouts and types.
`default_nettype none
package ifb_pkg;

   // ------------------------------------------------------------------
   // Register byte offsets on the APB side.
   // ------------------------------------------------------------------
   localparam logic [11:0] OFS_FLAGS_0   = 12'h000;
   localparam logic [11:0] OFS_FLAGS_1   = 12'h004;
   localparam logic [11:0] OFS_FLAGS_4   = 12'h008;
   localparam logic [11:0] OFS_ENABLES_0 = 12'h00c;
   localparam logic [11:0] OFS_ENABLES_1 = 12'h010;
   localparam logic [11:0] OFS_ENABLES_4 = 12'h014;
   localparam logic [11:0] OFS_IRQ_STAT  = 12'h018;
   localparam logic [11:0] OFS_IRQ_CLR   = 12'h01c;
   localparam logic [11:0] OFS_IRQ_EN    = 12'h020;

   // ------------------------------------------------------------------
   // Masks of implemented bits; all other positions read zero.
   // ------------------------------------------------------------------
   localparam logic [15:0] MASK_BANK_0 = 16'h3fef;
   localparam logic [15:0] MASK_BANK_1 = 16'h20db;
   localparam logic [15:0] MASK_BANK_4 = 16'h0002;
   localparam logic [15:0] REG_RESET   = 16'h0000;
   localparam int          REG_W       = 16;
   localparam int          BANKS       = 3;

   // Block status bits: bit 0 set when the first enabled request becomes pending.
   localparam logic [1:0]  STAT_MASK       = 2'h3;
   localparam int          STAT_NEW_REQ    = 0;
   localparam int          STAT_BAD_ACCESS = 1;

   // Named positions of the first bank.
   localparam int ADC_DONE_BIT = 13;
   localparam int EXT_PIN_ZERO_BIT = 0;
   // Named position in the third bank.
   localparam int SERIAL_ERROR_BIT = 1;

   typedef struct packed {
      logic [REG_W-1:0] bank0;
      logic [REG_W-1:0] bank1;
      logic [REG_W-1:0] bank4;
   } ifb_vec_t;

   typedef enum logic [1:0] {
      IFB_IDLE   = 2'b00,
      IFB_ACCESS = 2'b01
   } ifb_state_t;

endpackage
`default_nettype wire

//--- logic/ifb_bank.sv
// One flag register paired with its enable register and request gating.
`default_nettype none
module ifb_bank
   import ifb_pkg::*;
#(
   parameter logic [15:0] MASK = 16'h0000
) (
   input  wire  logic             pclk,
   input  wire  logic             presetn,
   input  wire  logic             clk_en,
   input  wire  logic [REG_W-1:0] src_req,
   input  wire  logic             flag_we,
   input  wire  logic             en_we,
   input  wire  logic [REG_W-1:0] wdata,
   output var   logic [REG_W-1:0] flags,
   output var   logic [REG_W-1:0] enables,
   output var   logic [REG_W-1:0] pending
);

   logic [REG_W-1:0] next_flags;
   logic [REG_W-1:0] next_enables;
   logic [REG_W-1:0] next_pending;

   // Software write first, then a source request ORs in so a set beats a clear.
   always_comb begin
      next_flags   = flags;
      next_enables = enables;
      if (flag_we) begin
         next_flags = wdata & MASK;
      end
      next_flags = (next_flags | src_req) & MASK;
      if (en_we) begin
         next_enables = wdata & MASK;
      end
      next_pending = next_flags & next_enables;
   end

   // Registers; reset clears everything so nothing pends after power-on.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags   <= REG_RESET;
         enables <= REG_RESET;
         pending <= REG_RESET;
      end else if (clk_en) begin
         flags   <= next_flags;
         enables <= next_enables;
         pending <= next_pending;
      end
   end

endmodule
`default_nettype wire

//--- logic/ifb_top.sv
// Interrupt flag and enable bank with APB register access and summary interrupt.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`default_nettype none
module ifb_top
   import ifb_pkg::*;
(
   input  wire  logic        pclk,
   input  wire  logic        presetn,
   input  wire  logic        clk_en,
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [11:0] paddr,
   input  wire  logic [31:0] pwdata,
   input  wire  logic [3:0]  pstrb,
   input  wire  ifb_vec_t    src_req,
   output var   logic [31:0] prdata,
   output var   logic        pready,
   output var   logic        pslverr,
   output var   ifb_vec_t    req_out,
   output var   logic        irq
);

   // ------------------------------------------------------------------
   // Bus slave state.
   // ------------------------------------------------------------------
   // The slave answers every transfer after exactly one wait state. The
   // request is taken at the first access edge, while ready is still low,
   // and ready, read data and the error flag are then registered together.
   // Ready and the error flag stand for a single cycle; read data holds until
   // the next transfer. A master that holds its request until it sees ready
   // high therefore needs no knowledge of the wait state count.
   // Back to back transfers are accepted, since idle follows ready at once.
   // Holding the clock enable low stalls the handshake with the rest.
   ifb_state_t       state;
   ifb_state_t       next_state;
   logic [31:0]      next_prdata;
   logic             next_pready;
   logic             next_pslverr;
   // Block status and its enable, two bits each.
   logic [1:0]       stat;
   logic [1:0]       next_stat;
   logic [1:0]       stat_en;
   logic [1:0]       next_stat_en;
   logic             next_irq;

   // Register images of the three banks, gathered into the shared carrier so
   // that the read mux and the summary logic see one coherent word.
   ifb_vec_t         flags;
   ifb_vec_t         enables;
   ifb_vec_t         pending;
   logic [BANKS-1:0] flag_we;
   logic [BANKS-1:0] en_we;
   logic [15:0]      wdata16;

   // Returns a 16-bit value widened into the low half of a bus word.
   // The upper half always reads zero since no register is wider than that.
   function automatic logic [31:0] widen(input logic [15:0] v);
      widen = {16'h0000, v};
   endfunction

   // A write is taken only in the access cycle and only while ready is low,
   // so each transfer commits exactly once, at its first access edge, one cycle before it completes.
   // The clock enable is part of the condition, so a frozen edge commits nothing.
   logic take;
   assign take    = psel && penable && !pready && clk_en;
   assign wdata16 = pwdata[15:0];

   // ------------------------------------------------------------------
   // Write decode into the banks.
   // ------------------------------------------------------------------
   // Only the low strobe pair matters because every register is sixteen bits
   // wide and lives in the low half of its word. A write that names none of
   // the bank offsets falls through untouched here; the status and clear
   // offsets are handled next to the handshake, where the status bits live.
   // A bank write with both low strobes clear is dropped as a whole; status and clear writes ignore the strobes.
   always_comb begin
      // Nothing loads unless a decoded bank write is being taken.
      flag_we = '0;
      en_we   = '0;
      if (take && pwrite && (pstrb[1:0] != 2'b00)) begin
         if (paddr == OFS_FLAGS_0) begin
            flag_we[0] = 1'b1;
         end else if (paddr == OFS_FLAGS_1) begin
            flag_we[1] = 1'b1;
         end else if (paddr == OFS_FLAGS_4) begin
            flag_we[2] = 1'b1;
         end else if (paddr == OFS_ENABLES_0) begin
            en_we[0] = 1'b1;
         end else if (paddr == OFS_ENABLES_1) begin
            en_we[1] = 1'b1;
         end else if (paddr == OFS_ENABLES_4) begin
            en_we[2] = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // The three flag and enable banks.
   // ------------------------------------------------------------------
   // Each bank carries its own mask of implemented positions, so a bit that
   // does not exist can neither be written nor set by a stray source line.
   // The banks share the write data; only the address decode selects which one loads.
   // A source request in the same edge as a software clear keeps its flag.
   // First bank: thirteen sources, position four left empty.
   ifb_bank #(.MASK(MASK_BANK_0)) u_bank0 (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .src_req (src_req.bank0),
      .flag_we (flag_we[0]),
      .en_we   (en_we[0]),
      .wdata   (wdata16),
      .flags   (flags.bank0),
      .enables (enables.bank0),
      .pending (pending.bank0)
   );

   // Second bank: pin two, captures seven and eight, pin one, change
   // notification and both bus event sources.
   ifb_bank #(.MASK(MASK_BANK_1)) u_bank1 (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .src_req (src_req.bank1),
      .flag_we (flag_we[1]),
      .en_we   (en_we[1]),
      .wdata   (wdata16),
      .flags   (flags.bank1),
      .enables (enables.bank1),
      .pending (pending.bank1)
   );

   // Bank four: only the serial error position exists.
   ifb_bank #(.MASK(MASK_BANK_4)) u_bank4 (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .src_req (src_req.bank4),
      .flag_we (flag_we[2]),
      .en_we   (en_we[2]),
      .wdata   (wdata16),
      .flags   (flags.bank4),
      .enables (enables.bank4),
      .pending (pending.bank4)
   );

   // Gated requests go onward straight from the bank flip-flops.
   // Priority resolution sits outside this block; the gated word changes on
   // the same edge as the flag itself, so no extra delay is added here.
   assign req_out = pending;

   // ------------------------------------------------------------------
   // Read mux, status events and handshake.
   // ------------------------------------------------------------------
   // Limitation: the block assumes a single master and does not check that
   // the address stays constant during the access phase. A master that
   // changes the address between the two access edges reads the register
   // named at the taking edge and receives the error response for that
   // offset as well.

   // The summary edge detector watches the gated word as a whole. It sets the
   // new request status bit once when the first enabled request appears, not
   // again for requests that join while one is already pending, so software
   // must read the banks to learn which sources are waiting.
   logic any_pend;
   logic any_pend_d;
   logic next_any_pend_d;
   logic bad_addr;

   // Any enabled request anywhere in the three banks.
   assign any_pend = |{pending.bank0, pending.bank1, pending.bank4};

   // Unmapped offsets answer with an error and zero data.
   // The error status bit records the event so that a driver polling the
   // status register can notice a stray access after the fact.
   always_comb begin
      bad_addr = 1'b1;
      if ((paddr == OFS_FLAGS_0) || (paddr == OFS_FLAGS_1) || (paddr == OFS_FLAGS_4)) begin
         bad_addr = 1'b0;
      end else if ((paddr == OFS_ENABLES_0) || (paddr == OFS_ENABLES_1)) begin
         bad_addr = 1'b0;
      end else if ((paddr == OFS_ENABLES_4) || (paddr == OFS_IRQ_STAT)) begin
         bad_addr = 1'b0;
      end else if ((paddr == OFS_IRQ_CLR) || (paddr == OFS_IRQ_EN)) begin
         bad_addr = 1'b0;
      end
   end

   // Reads capture the register image at the taking edge, so a flag set in
   // that same edge shows up only on the next read. That is the price of a
   // registered read path.
   // One wait state: ready rises one cycle after the access phase begins,
   // which keeps the read mux off the critical path.
   always_comb begin
      next_state      = state;
      next_prdata     = prdata;
      next_pready     = 1'b0;
      next_pslverr    = 1'b0;
      next_stat       = stat;
      next_stat_en    = stat_en;
      next_any_pend_d = any_pend;
      // Every output has a default above, so the case only lists changes.
      case (state)
         IFB_IDLE: begin
            // Only a taking edge starts work; everything else waits here.
            if (take) begin
               next_state   = IFB_ACCESS;
               next_pready  = 1'b1;
               next_pslverr = bad_addr;
               // Clear the read word first so unmapped reads return zero.
               next_prdata  = 32'h0000_0000;
               // Reads pick one image; offsets without a readable register,
               // the clear register among them, return zero.
               if (!pwrite) begin
                  if (paddr == OFS_FLAGS_0) begin
                     next_prdata = widen(flags.bank0);
                  end else if (paddr == OFS_FLAGS_1) begin
                     next_prdata = widen(flags.bank1);
                  end else if (paddr == OFS_FLAGS_4) begin
                     next_prdata = widen(flags.bank4);
                  end else if (paddr == OFS_ENABLES_0) begin
                     next_prdata = widen(enables.bank0);
                  end else if (paddr == OFS_ENABLES_1) begin
                     next_prdata = widen(enables.bank1);
                  end else if (paddr == OFS_ENABLES_4) begin
                     next_prdata = widen(enables.bank4);
                  end else if (paddr == OFS_IRQ_STAT) begin
                     next_prdata = {30'h0000_0000, stat};
                  end else if (paddr == OFS_IRQ_EN) begin
                     next_prdata = {30'h0000_0000, stat_en};
                  end
               end else if (paddr == OFS_IRQ_CLR) begin
                  next_stat = stat & ~pwdata[1:0];
               end else if (paddr == OFS_IRQ_EN) begin
                  next_stat_en = pwdata[1:0] & STAT_MASK;
               end
               // A stray access is flagged whether it was a read or a write.
               if (bad_addr) begin
                  next_stat[STAT_BAD_ACCESS] = 1'b1;
               end
            end
         end
         IFB_ACCESS: begin
            // Ready is high in this cycle; the master releases its request
            // at the edge that ends it, so the slave simply returns to idle.
            next_state = IFB_IDLE;
         end
         default: begin
            // Unused codes recover to idle rather than lock the bus.
            next_state = IFB_IDLE;
         end
      endcase
      // Event sets are applied last so they win over a same-cycle clear.
      // The detector uses the registered gated word, which changes on the same edge as the flags.
      if (any_pend && !any_pend_d) begin
         next_stat[STAT_NEW_REQ] = 1'b1;
      end
      // The interrupt follows the next status so it rises with the bit.
      next_irq = |(next_stat & next_stat_en);
   end

   // Registers for the handshake, read data and summary interrupt. The
   // asynchronous reset loads constants only, and a low clock enable holds
   // every one of them, including a half finished handshake, so a stalled
   // transfer resumes exactly where it stopped. The interrupt output comes
   // straight from a flip-flop, which keeps glitches off the line.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= IFB_IDLE;
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         stat       <= 2'h0;
         stat_en    <= 2'h0;
         any_pend_d <= 1'b0;
         irq        <= 1'b0;
      end else if (clk_en) begin
         state      <= next_state;
         prdata     <= next_prdata;
         pready     <= next_pready;
         pslverr    <= next_pslverr;
         stat       <= next_stat;
         stat_en    <= next_stat_en;
         any_pend_d <= next_any_pend_d;
         irq        <= next_irq;
      end
   end

endmodule
`default_nettype wire

//--- sim/ifb_chk.sv
// Port checker for the flag and enable bank, bound to its top module.
`default_nettype none
module ifb_chk
   import ifb_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        clk_en,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire ifb_vec_t    req_out,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   // All checks sample on pclk; all but the reset check are muted while reset is low.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_m0; (req_out.bank0 & ~MASK_BANK_0) == 16'h0000; endproperty
   property p_m1; (req_out.bank1 & ~MASK_BANK_1) == 16'h0000; endproperty
   property p_m4; (req_out.bank4 & ~MASK_BANK_4) == 16'h0000; endproperty
   // Reset must clear outputs even though the default disable is set.
   property p_rst;
      disable iff (1'b0) !presetn |-> (req_out == '0 && !irq && !pready);
   endproperty
   // Without a write a pending gated request may only gain bits.
   property p_stick;
      !(psel && penable && pwrite) |=> (req_out & $past(req_out)) == $past(req_out);
   endproperty
   property p_ans; psel && penable && !pready && clk_en |=> pready; endproperty
   property p_pulse; pready |=> !pready; endproperty
   property p_hi; pready |-> prdata[31:16] == 16'h0000; endproperty
   a_m0: assert property (p_m0) else $error("bank0 spare bit set");
   a_m1: assert property (p_m1) else $error("bank1 spare bit set");
   a_m4: assert property (p_m4) else $error("bank4 spare bit set");
   a_rst: assert property (p_rst) else $error("outputs live in reset");
   a_stick: assert property (p_stick) else $error("request dropped");
   a_ans: assert property (p_ans) else $error("no answer");
   a_pulse: assert property (p_pulse) else $error("ready held");
   a_hi: assert property (p_hi) else $error("upper read bits set");
   c_irq: cover property ($rose(irq));
   c_err: cover property (pready && pslverr);
   c_req: cover property (req_out != '0);
endmodule
bind ifb_top ifb_chk u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .req_out(req_out), .irq(irq));
`default_nettype wire

//--- sim/ifb_src_model.sv
// Request source model: raises a one-cycle pattern of source requests.
`default_nettype none
module ifb_src_model
   import ifb_pkg::*;
(
   input  wire logic     pclk,
   input  wire logic     presetn,
   input  wire logic     fire,
   input  wire ifb_vec_t pat,
   output var  ifb_vec_t src_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // A pulse is the harder case, since the flag alone must remember it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) src_req <= '0;
      else src_req <= fire ? pat : '0;
   end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the flag and enable bank with a shadow model.
`default_nettype none
module testbench
   import ifb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        ce = 1'b1;
   logic [3:0]  strb = 4'hf;
   logic        pwrite = 1'b0, fire = 1'b0, pready, pslverr, irq, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   ifb_vec_t    pat = '0, src_req, req_out;
   logic [15:0] mf[3], me[3], mk[3], p[3];
   int          errors = 0, total_checks = 0;
   // ------------------------------------------------------------------
   // Clock, sources and device
   // ------------------------------------------------------------------
   always #20 pclk = ~pclk;
   ifb_src_model u_src (.pclk(pclk), .presetn(presetn), .fire(fire), .pat(pat),
      .src_req(src_req));
   ifb_top u_dut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(strb), .src_req(src_req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .req_out(req_out), .irq(irq));
   task automatic summarize;
      if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One APB transfer; an idle cycle follows so no signal is set twice at once.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
         $display("Error %0t: no bus answer", $time);
      end
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [47:0] e);
      apb(1'b0, a, 32'h0);
      chk(48'(r), e);
   endtask
   task automatic wrb(input int b, input bit en, input logic [15:0] d);
      apb(1'b1, (en ? OFS_ENABLES_0 : OFS_FLAGS_0) + 12'(4 * b), {16'h0, d});
      if (en) me[b] = d & mk[b];
      else mf[b] = d & mk[b];
   endtask
   task automatic chk_all;
      for (int b = 0; b < 3; b++) begin
         rd(OFS_FLAGS_0 + 12'(4 * b), 48'(mf[b]));
         rd(OFS_ENABLES_0 + 12'(4 * b), 48'(me[b]));
      end
      chk(req_out, {mf[0] & me[0], mf[1] & me[1], mf[2] & me[2]});
   endtask
   task automatic fire_src;
      pat <= {p[0], p[1], p[2]};
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      repeat (3) @(posedge pclk);
      for (int b = 0; b < 3; b++) mf[b] |= p[b] & mk[b];
   endtask
   task automatic rst;
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int b = 0; b < 3; b++) {mf[b], me[b], p[b]} = '0;
   endtask
   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   // Each phase leaves the shadow model exact, so later phases build on it.
   initial begin
      mk = '{MASK_BANK_0, MASK_BANK_1, MASK_BANK_4};
      void'($urandom(32'h531b));
      rst();
      chk_all();
      for (int i = 0; i < 6; i++) wrb(i / 2, i % 2, 16'hffff);
      chk_all();
      for (int i = 0; i < 6; i++) wrb(i / 2, i % 2, 16'h0000);
      repeat (10) wrb($urandom_range(2), 1'($urandom_range(1)), 16'($urandom));
      chk_all();
      repeat (6) begin
         for (int b = 0; b < 3; b++) p[b] = 16'($urandom);
         fire_src();
         chk_all();
      end
      // A write whose strobes miss the low half must leave every flag alone.
      strb <= 4'hc;
      apb(1'b1, OFS_FLAGS_0, 32'h0000_ffff);
      strb <= 4'hf;
      chk_all();
      for (int b = 0; b < 3; b++) wrb(b, 1'b0, 16'h0000);
      chk_all();
      apb(1'b1, OFS_IRQ_CLR, 32'h3);
      rd(OFS_IRQ_STAT, 48'h0);
      apb(1'b1, OFS_IRQ_EN, 32'h1);
      wrb(0, 1'b1, 16'h2000);
      p = '{16'h2000, 16'h0000, 16'h0000};
      fire_src();
      chk(48'(irq), 48'h1);
      rd(OFS_IRQ_STAT, 48'h1);
      apb(1'b1, OFS_IRQ_EN, 32'h0);
      chk(48'(irq), 48'h0);
      rd(12'h100, 48'h0);
      chk(48'(er), 48'h1);
      rd(OFS_IRQ_STAT, 48'h3);
      // Requests raised while the clock enable is low must not reach the flags.
      ce <= 1'b0;
      pat <= '1;
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      repeat (3) @(posedge pclk);
      ce <= 1'b1;
      @(posedge pclk);
      chk_all();
      rst();
      chk_all();
      summarize();
   end
   // Cuts a hang short well beyond the expected run of a few hundred cycles.
   initial begin
      #2000000;
      errors++;
      summarize();
   end
endmodule
`default_nettype wire
